/* shared/csts_pkg.sv */
// constants and types for the capture sync/trigger source select block
// assumes a single clock domain and an AXI4-Lite register slave
package csts_pkg;

    // register bus
    localparam int          CSTS_ADDR_W     = 8;
    localparam int          CSTS_DATA_W     = 32;
    localparam logic [7:0]  OFF_CTRL_TWO    = 8'h00;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h04;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h08;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // capture_control_two layout
    localparam int          CTRL_W          = 16;
    localparam int          SEL_W           = 5;
    localparam int          SEL_LSB         = 0;
    localparam int          TRIG_STAT_BIT   = 7;
    localparam int          CASCADE_BIT     = 8;
    localparam int          LO_LANE         = 0;
    localparam int          HI_LANE         = 1;

    // interrupt status and mask layout
    localparam int          IRQ_W           = 1;
    localparam int          IRQ_TRIG_BIT    = 0;
    localparam logic [IRQ_W-1:0] IRQ_RESET  = 1'h0;

    // source select codes
    localparam logic [SEL_W-1:0] SRC_NONE_LO  = 5'h00;
    localparam logic [SEL_W-1:0] SRC_OC_FIRST = 5'h01;
    localparam logic [SEL_W-1:0] SRC_OC_LAST  = 5'h04;
    localparam logic [SEL_W-1:0] SRC_TGO      = 5'h0a;
    localparam logic [SEL_W-1:0] SRC_TMR_FIRST = 5'h0b;
    localparam logic [SEL_W-1:0] SRC_TMR_LAST = 5'h0f;
    localparam logic [SEL_W-1:0] SRC_IC_FIRST = 5'h10;
    localparam logic [SEL_W-1:0] SRC_IC_LAST  = 5'h13;
    localparam logic [SEL_W-1:0] SRC_CMP_FIRST = 5'h18;
    localparam logic [SEL_W-1:0] SRC_CMP_LAST = 5'h1a;
    localparam logic [SEL_W-1:0] SRC_ADC      = 5'h1b;
    localparam logic [SEL_W-1:0] SRC_CTU      = 5'h1c;
    localparam logic [SEL_W-1:0] SRC_NONE_HI  = 5'h1f;
    localparam logic [SEL_W-1:0] SRC_DEFAULT  = 5'h0d;

    // event source counts
    localparam int          N_TMR           = 5;
    localparam int          N_IC            = 4;
    localparam int          N_OC            = 4;
    localparam int          N_CMP           = 3;
    localparam int          N_TGO           = 4;

    typedef struct packed {
        logic [N_TMR-1:0] timer;
        logic [N_IC-1:0]  capture_unit;
        logic [N_OC-1:0]  output_compare;
        logic [N_CMP-1:0] comparator;
        logic             analog_converter_one;
        logic             charge_time_unit;
        logic [N_TGO-1:0] trigger_generator_output;
    } csts_evt_type;

endpackage

/* rtl/csts_src_mux.sv */
// combinational source selector for one capture unit
// assumes event inputs are one-cycle pulses synchronous to the clock
`timescale 1ns/1ps
module csts_src_mux #(
    parameter int UNIT_INDEX = 0
) (
    input  wire logic [csts_pkg::SEL_W-1:0] sel,
    input  wire csts_pkg::csts_evt_type     evt,
    output logic                            sel_evt
);
    import csts_pkg::*;

    logic [SEL_W-1:0] oc_off;
    logic [SEL_W-1:0] tmr_off;
    logic [SEL_W-1:0] ic_off;
    logic [SEL_W-1:0] cmp_off;

    assign oc_off  = sel - SRC_OC_FIRST;
    assign tmr_off = sel - SRC_TMR_FIRST;
    assign ic_off  = sel - SRC_IC_FIRST;
    assign cmp_off = sel - SRC_CMP_FIRST;

    // reserved codes and both no-source codes fall to the final zero
    always_comb begin
        sel_evt = 1'b0;
        if (sel >= SRC_OC_FIRST && sel <= SRC_OC_LAST) begin
            sel_evt = evt.output_compare[oc_off[1:0]];
        end else if (sel == SRC_TGO) begin
            sel_evt = evt.trigger_generator_output[UNIT_INDEX];
        end else if (sel >= SRC_TMR_FIRST && sel <= SRC_TMR_LAST) begin
            sel_evt = evt.timer[tmr_off[2:0]];
        end else if (sel >= SRC_IC_FIRST && sel <= SRC_IC_LAST) begin
            sel_evt = evt.capture_unit[ic_off[1:0]];
        end else if (sel >= SRC_CMP_FIRST && sel <= SRC_CMP_LAST) begin
            sel_evt = evt.comparator[cmp_off[1:0]];
        end else if (sel == SRC_ADC) begin
            sel_evt = evt.analog_converter_one;
        end else if (sel == SRC_CTU) begin
            sel_evt = evt.charge_time_unit;
        end else begin
            sel_evt = 1'b0;
        end
    end

endmodule

/* rtl/csts_top.sv */
// capture unit sync/trigger source select with AXI4-Lite registers
// assumes event inputs are synchronous single-cycle pulses on aclk
//
// Operation
// - five-bit source select in control bits 4..0
// - codes 11111 and 00000 give no source
// - select resets to 01101, third timer
// - 01011..01111 pick timers one to five
// - 10000..10011 pick capture units one to four
// - 00001..00100 pick output compares one to four
// - 11000..11010 comparators, 11011 converter event
// - 11100 picks the charge time unit
// - 01010 picks this unit's trigger generator output
// - selected event sets status; software sets/clears
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module csts_top #(
    parameter int UNIT_INDEX = 0
) (
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic [csts_pkg::CSTS_ADDR_W-1:0] awaddr,
    input  wire logic                             awvalid,
    output logic                                  awready,
    input  wire logic [csts_pkg::CSTS_DATA_W-1:0] wdata,
    input  wire logic [3:0]                       wstrb,
    input  wire logic                             wvalid,
    output logic                                  wready,
    output logic [1:0]                            bresp,
    output logic                                  bvalid,
    input  wire logic                             bready,
    input  wire logic [csts_pkg::CSTS_ADDR_W-1:0] araddr,
    input  wire logic                             arvalid,
    output logic                                  arready,
    output logic [csts_pkg::CSTS_DATA_W-1:0]      rdata,
    output logic [1:0]                            rresp,
    output logic                                  rvalid,
    input  wire logic                             rready,
    input  wire csts_pkg::csts_evt_type           evt_in,
    input  wire logic                             partner_cascade_enable,
    output logic                                  sync_trigger_out,
    output logic                                  trigger_status,
    output logic                                  cascade_active,
    output logic                                  irq
);
    import csts_pkg::*;

    // bus handshake state
    logic                   awready_ff;
    logic                   wready_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;
    logic                   arready_ff;
    logic                   rvalid_ff;
    logic [1:0]             rresp_ff;
    logic [CSTS_DATA_W-1:0] rdata_ff;
    logic                   aw_hold_ff;
    logic                   w_hold_ff;
    logic [CSTS_ADDR_W-1:0] waddr_ff;
    logic [CSTS_DATA_W-1:0] wdata_ff;
    logic [3:0]             wstrb_ff;

    // block state
    logic [SEL_W-1:0]       sel_ff;
    logic                   trig_stat_ff;
    logic                   cas_en_ff;
    logic [IRQ_W-1:0]       irq_stat_ff;
    logic [IRQ_W-1:0]       irq_mask_ff;
    logic                   sync_out_ff;
    logic                   cas_act_ff;
    logic                   irq_ff;

    // next values
    logic                   nxt_aw_hold;
    logic                   nxt_w_hold;
    logic                   nxt_bvalid;
    logic                   nxt_rvalid;
    logic [SEL_W-1:0]       nxt_sel;
    logic                   nxt_trig_stat;
    logic                   nxt_cas_en;
    logic [IRQ_W-1:0]       nxt_irq_stat;
    logic [IRQ_W-1:0]       nxt_irq_mask;

    // decode wires
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic                   wr_do;
    logic                   wr_ctrl;
    logic                   wr_stat;
    logic                   wr_mask;
    logic                   wr_hit;
    logic                   rd_hit;
    logic                   lo_en;
    logic                   hi_en;
    logic                   sel_evt;
    logic [CSTS_DATA_W-1:0] ctrl_word;
    logic [CSTS_DATA_W-1:0] rd_word;
    logic [IRQ_W-1:0]       evt_vec;
    logic [IRQ_W-1:0]       clr_vec;

    csts_src_mux #(
        .UNIT_INDEX (UNIT_INDEX)
    ) u_mux (
        .sel        (sel_ff),
        .evt        (evt_in),
        .sel_evt    (sel_evt)
    );

    // write channel: address and data may arrive in either order
    assign aw_take     = awvalid && awready_ff;
    assign w_take      = wvalid && wready_ff;
    assign wr_do       = aw_hold_ff && w_hold_ff;
    assign nxt_aw_hold = aw_take || (aw_hold_ff && !wr_do);
    assign nxt_w_hold  = w_take || (w_hold_ff && !wr_do);
    assign nxt_bvalid  = wr_do || (bvalid_ff && !bready);

    assign wr_ctrl = wr_do && (waddr_ff == OFF_CTRL_TWO);
    assign wr_stat = wr_do && (waddr_ff == OFF_IRQ_STATUS);
    assign wr_mask = wr_do && (waddr_ff == OFF_IRQ_MASK);
    assign wr_hit  = wr_ctrl || wr_stat || wr_mask;
    assign lo_en   = wstrb_ff[LO_LANE];
    assign hi_en   = wstrb_ff[HI_LANE];

    // read channel: one outstanding read, arready drops while rvalid
    assign ar_take    = arvalid && arready_ff;
    assign nxt_rvalid = ar_take || (rvalid_ff && !rready);
    assign rd_hit     = (araddr == OFF_CTRL_TWO) || (araddr == OFF_IRQ_STATUS) || (araddr == OFF_IRQ_MASK);

    assign ctrl_word = (CSTS_DATA_W'(sel_ff) << SEL_LSB)
                     | (CSTS_DATA_W'(trig_stat_ff) << TRIG_STAT_BIT)
                     | (CSTS_DATA_W'(cas_en_ff) << CASCADE_BIT);
    assign rd_word = (araddr == OFF_CTRL_TWO)   ? ctrl_word :
                     (araddr == OFF_IRQ_STATUS) ? CSTS_DATA_W'(irq_stat_ff) :
                     (araddr == OFF_IRQ_MASK)   ? CSTS_DATA_W'(irq_mask_ff) : '0;

    // control register fields
    assign nxt_sel    = (wr_ctrl && lo_en) ? wdata_ff[SEL_LSB +: SEL_W] : sel_ff;
    assign nxt_cas_en = (wr_ctrl && hi_en) ? wdata_ff[CASCADE_BIT] : cas_en_ff;
    // hardware set beats a software clear in the same cycle
    assign nxt_trig_stat = sel_evt ? 1'b1 :
                           ((wr_ctrl && lo_en) ? wdata_ff[TRIG_STAT_BIT] : trig_stat_ff);

    // sticky interrupt status, write one to clear, set wins
    assign evt_vec      = IRQ_W'(sel_evt) << IRQ_TRIG_BIT;
    assign clr_vec      = (wr_stat && lo_en) ? wdata_ff[IRQ_W-1:0] : '0;
    assign nxt_irq_stat = evt_vec | (irq_stat_ff & ~clr_vec);
    assign nxt_irq_mask = (wr_mask && lo_en) ? wdata_ff[IRQ_W-1:0] : irq_mask_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff  <= nxt_w_hold;
            awready_ff <= !nxt_aw_hold && !nxt_bvalid;
            wready_ff  <= !nxt_w_hold && !nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            if (wr_do) begin
                bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (aw_take) begin
                waddr_ff <= awaddr;
            end
            if (w_take) begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= '0;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff       <= SRC_DEFAULT;
            trig_stat_ff <= 1'b0;
            cas_en_ff    <= 1'b0;
            irq_stat_ff  <= IRQ_RESET;
            irq_mask_ff  <= IRQ_RESET;
        end else begin
            sel_ff       <= nxt_sel;
            trig_stat_ff <= nxt_trig_stat;
            cas_en_ff    <= nxt_cas_en;
            irq_stat_ff  <= nxt_irq_stat;
            irq_mask_ff  <= nxt_irq_mask;
        end
    end

    // irq follows the next-state values so it tracks status without lag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_out_ff <= 1'b0;
            cas_act_ff  <= 1'b0;
            irq_ff      <= 1'b0;
        end else begin
            sync_out_ff <= sel_evt;
            cas_act_ff  <= cas_en_ff && partner_cascade_enable;
            irq_ff      <= |(nxt_irq_stat & nxt_irq_mask);
        end
    end

    assign awready          = awready_ff;
    assign wready           = wready_ff;
    assign bvalid           = bvalid_ff;
    assign bresp            = bresp_ff;
    assign arready          = arready_ff;
    assign rvalid           = rvalid_ff;
    assign rresp            = rresp_ff;
    assign rdata            = rdata_ff;
    assign sync_trigger_out = sync_out_ff;
    assign trigger_status   = trig_stat_ff;
    assign cascade_active   = cas_act_ff;
    assign irq              = irq_ff;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sel_reset_a: assert property (disable iff (1'b0) !aresetn |=> sel_ff == SRC_DEFAULT)
        else $error("source select did not reset to third timer");

    sel_write_a: assert property (wr_ctrl && lo_en |=> sel_ff == $past(wdata_ff[SEL_LSB +: SEL_W]))
        else $error("source select field not written");

    no_source_a: assert property ((sel_ff == SRC_NONE_LO || sel_ff == SRC_NONE_HI) |=> !sync_trigger_out)
        else $error("no-source code produced an event");

    timer_route_a: assert property (sel_ff == SRC_DEFAULT && evt_in.timer[2] |=> sync_trigger_out)
        else $error("third timer event not routed");

    capture_route_a: assert property (sel_ff == SRC_IC_LAST && evt_in.capture_unit[N_IC-1] |=> sync_trigger_out)
        else $error("fourth capture unit event not routed");

    compare_route_a: assert property (sel_ff == SRC_OC_FIRST |=> sync_trigger_out == $past(evt_in.output_compare[0]))
        else $error("first output compare routing wrong");

    analog_route_a: assert property (sel_ff == SRC_ADC |=> sync_trigger_out == $past(evt_in.analog_converter_one))
        else $error("converter routing wrong");

    charge_route_a: assert property (sel_ff == SRC_CTU |=> sync_trigger_out == $past(evt_in.charge_time_unit))
        else $error("charge time unit routing wrong");

    tgo_route_a: assert property (sel_ff == SRC_TGO |=>
                                  sync_trigger_out == $past(evt_in.trigger_generator_output[UNIT_INDEX]))
        else $error("trigger generator output routing wrong");

    status_set_a: assert property (sync_trigger_out |-> trigger_status && irq_stat_ff[IRQ_TRIG_BIT])
        else $error("selected event did not set status");

    reserved_code_a: assert property ((sel_ff > SRC_CTU && sel_ff < SRC_NONE_HI) ||
                                      (sel_ff > SRC_IC_LAST && sel_ff < SRC_CMP_FIRST) ||
                                      (sel_ff > SRC_OC_LAST && sel_ff < SRC_TGO) |=> !sync_trigger_out)
        else $error("reserved code produced an event");

    cascade_pair_a: assert property (##1 cascade_active == $past(cas_en_ff && partner_cascade_enable))
        else $error("cascade active does not follow both enables");

    trig_cover_c: cover property (sync_trigger_out ##1 irq);
    clear_cover_c: cover property (trigger_status ##1 !trigger_status);
    cascade_cover_c: cover property ($rose(cascade_active));
    slverr_cover_c: cover property (bvalid && bresp == RESP_SLVERR);

endmodule

/* tb/csts_evt_src.sv */
// partner model: peripheral event sources and the paired capture unit
// assumes the bench asks for a pulse one cycle ahead on fire_go
`timescale 1ns/1ps
module csts_evt_src (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [21:0]            fire_vec,
    input  wire logic                   fire_go,
    input  wire logic                   cascade_req,
    output csts_pkg::csts_evt_type      evt,
    output logic                        cascade_out
);
    import csts_pkg::*;
    // events are single-cycle pulses, idle low between them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt         <= '0;
            cascade_out <= 1'b0;
        end else begin
            evt         <= fire_go ? csts_evt_type'(fire_vec) : '0;
            cascade_out <= cascade_req;
        end
    end
endmodule

/* tb/csts_top_tb.sv */
// self-checking bench for the capture source select block
// assumes one 25 MHz clock and AXI4-Lite register access
`timescale 1ns/1ps
module csts_top_tb;
    import csts_pkg::*;
    localparam int UNIT = 1;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, stout, tstat, casc, irq, fire_go = 0, casc_req = 0;
    logic [1:0] bresp, rresp;
    logic [21:0] fire_vec = '0;
    csts_evt_type evt;
    int errors = 0, checked = 0, cycles = 0, idx;
    integer seed = 65;
    logic [21:0] v;
    logic e, st, casc_q;
    always #20 aclk = ~aclk;
    csts_top #(.UNIT_INDEX(UNIT)) i_csts_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .evt_in(evt), .partner_cascade_enable(casc), .sync_trigger_out(stout),
        .trigger_status(tstat), .cascade_active(casc_q), .irq(irq));
    csts_evt_src i_csts_evt_src (.aclk(aclk), .aresetn(aresetn), .fire_vec(fire_vec),
        .fire_go(fire_go), .cascade_req(casc_req), .evt(evt), .cascade_out(casc));
    task automatic report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, dd;
        ad = 0;
        dd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1;
                awvalid <= 0;
            end
            if (!dd && wready) begin
                dd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    // pulse reaches the block one edge after the request, answer one edge later
    task automatic fire(input logic [21:0] fv);
        fire_vec <= fv;
        fire_go <= 1;
        @(posedge aclk);
        fire_go <= 0;
        repeat (2) @(posedge aclk);
    endtask
    function automatic int src_idx(input int s);
        if (s >= 1 && s <= 4) return 9 + s - 1;
        if (s == 10) return UNIT;
        if (s >= 11 && s <= 15) return 17 + s - 11;
        if (s >= 16 && s <= 19) return 13 + s - 16;
        if (s >= 24 && s <= 26) return 6 + s - 24;
        if (s == 27) return 5;
        if (s == 28) return 4;
        return -1;
    endfunction
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(OFF_CTRL_TWO, 32'(SRC_DEFAULT), RESP_OKAY);
        rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
        rd(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
        rd(8'h0c, 32'h0, RESP_SLVERR);
        wr(8'h0c, 32'hffffffff, RESP_SLVERR);
        chk(32'(tstat), 32'h0);
        wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
        $display("test reset and map done");
        for (int c = 0; c < 32; c++) begin
            if (c == 16 + UNIT) continue;
            // capture unit code 16 + UNIT is skipped; every other code is swept
            wr(OFF_CTRL_TWO, 32'(c), RESP_OKAY);
            wr(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
            idx = src_idx(c);
            st = 0;
            for (int k = 0; k < 8; k++) begin
                v = 22'($random(seed));
                if (k == 0) v = (idx >= 0) ? 22'(1) << idx : 22'h3fffff;
                fire(v);
                e = (idx >= 0) ? v[idx] : 1'b0;
                chk(32'(stout), 32'(e));
                st = st | e;
                chk(32'(tstat), 32'(st));
                chk(32'(irq), 32'(st));
            end
            rd(OFF_CTRL_TWO, {24'h0, st, 2'h0, 5'(c)}, RESP_OKAY);
        end
        $display("test source sweep done");
        wr(OFF_CTRL_TWO, {24'h0, 8'h80 | 8'(SRC_NONE_HI)}, RESP_OKAY);
        chk(32'(tstat), 32'h1);
        wr(OFF_CTRL_TWO, 32'(SRC_NONE_HI), RESP_OKAY);
        chk(32'(tstat), 32'h0);
        $display("test software status done");
        wr(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
        wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
        wr(OFF_CTRL_TWO, 32'(SRC_TGO), RESP_OKAY);
        fire(22'(1) << UNIT);
        chk(32'(irq), 32'h0);
        rd(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
        wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
        chk(32'(irq), 32'h1);
        wr(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
        chk(32'(irq), 32'h0);
        $display("test interrupt done");
        // upper lane only: select and status must keep their values
        wstrb <= 4'h2;
        wr(OFF_CTRL_TWO, 32'h100, RESP_OKAY);
        wstrb <= 4'hf;
        repeat (3) @(posedge aclk);
        chk(32'(casc_q), 32'h0);
        casc_req <= 1;
        repeat (3) @(posedge aclk);
        chk(32'(casc_q), 32'h1);
        rd(OFF_CTRL_TWO, 32'h180 | 32'(SRC_TGO), RESP_OKAY);
        $display("test cascade done");
        report_and_stop();
    end
endmodule
